// ==== include/qdsw_pkg.sv ====
package qdsw_pkg;

    // Serial word layout
    localparam int          WORD_BITS   = 24;
    localparam int          CNT_W       = 5;
    localparam logic [4:0]  WORD_CNT    = 5'h18;
    localparam int          DATA_BITS   = 16;
    localparam int          ENTRY_BITS  = 17;
    localparam int          NUM_CH      = 4;
    localparam int          POS_ADDR_HI = 23;
    localparam int          POS_ADDR_LO = 22;
    localparam int          POS_LOAD_HI = 21;
    localparam int          POS_LOAD_LO = 20;
    localparam int          POS_SEL_HI  = 18;
    localparam int          POS_SEL_LO  = 17;
    localparam int          POS_PD_FLAG = 16;
    localparam int          POS_PD_HI   = 15;
    localparam int          POS_PD_LO   = 14;

    // Load commands
    typedef enum logic [1:0] {
        LOAD_STORE  = 2'h0,
        LOAD_UPDATE = 2'h1,
        LOAD_SIMUL  = 2'h2,
        LOAD_BCAST  = 2'h3
    } qdsw_load_t;

    // Output stage state of a channel
    typedef enum logic [1:0] {
        OUT_ACTIVE = 2'h0,
        OUT_HIZ    = 2'h1,
        OUT_1K     = 2'h2,
        OUT_100K   = 2'h3
    } qdsw_out_t;

    // Power-down codes in the payload
    localparam logic [1:0]  PD_HIZ_A    = 2'h0;
    localparam logic [1:0]  PD_1K       = 2'h1;
    localparam logic [1:0]  PD_100K     = 2'h2;

    // Register word indices, byte address is four times these
    localparam logic [3:0]  REG_CTRL    = 4'h0;
    localparam logic [3:0]  REG_STATUS  = 4'h1;
    localparam logic [3:0]  REG_COUNT   = 4'h2;
    localparam logic [3:0]  REG_DAC0    = 4'h4;
    localparam logic [3:0]  REG_BUF0    = 4'h8;
    localparam int          CTRL_EN_BIT = 0;
    localparam logic        CTRL_EN_RST = 1'b1;
    localparam logic [16:0] ENTRY_RST   = 17'h0_0000;
    localparam logic [15:0] COUNT_RST   = 16'h0000;
    localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

    // Host side timing, kept for reference only, the bench and the RTL do not use it
    localparam int          SYS_CLK_MHZ     = 40;
    localparam int          FRAME_GAP_NS    = 130;
    localparam int          FRAME_GAP_CYC   = (FRAME_GAP_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int          SER_MAX_HI_MHZ  = 50;
    localparam int          SER_MAX_LO_MHZ  = 25;
    localparam int          CODE_SPAN       = 65536;

endpackage

// ==== rtl/qdsw_sync.sv ====
`timescale 1ns/1ps
module qdsw_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] stage;
    logic [W-1:0] next_stage;
    logic [W-1:0] next_q;

    always_comb begin
        next_stage = d;
        next_q     = stage;
    end

    // First stage feeds only the second
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage <= '0;
            q     <= '0;
        end else begin
            stage <= next_stage;
            q     <= next_q;
        end
    end
endmodule

// ==== rtl/qdsw_channel.sv ====
`timescale 1ns/1ps
module qdsw_channel (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        buf_wr,
    input  wire logic        dac_from_word,
    input  wire logic        dac_from_buf,
    input  wire logic [16:0] entry,
    output logic      [16:0] buf_entry,
    output logic      [16:0] dac_entry,
    output logic      [1:0]  out_mode
);
    logic [16:0] next_buf;
    logic [16:0] next_dac;
    logic [1:0]  next_mode;

    always_comb begin
        next_buf = buf_entry;
        next_dac = dac_entry;
        if (buf_wr) begin
            next_buf = entry;
        end
        if (dac_from_word) begin
            next_dac = entry;
        end else if (dac_from_buf) begin
            next_dac = buf_entry;
        end
        // Power-down decode of the active entry
        if (!next_dac[qdsw_pkg::POS_PD_FLAG]) begin
            next_mode = qdsw_pkg::OUT_ACTIVE;
        end else begin
            unique case (next_dac[qdsw_pkg::POS_PD_HI:qdsw_pkg::POS_PD_LO])
                qdsw_pkg::PD_1K:   next_mode = qdsw_pkg::OUT_1K;
                qdsw_pkg::PD_100K: next_mode = qdsw_pkg::OUT_100K;
                default:           next_mode = qdsw_pkg::OUT_HIZ;
            endcase
        end
    end

    // Zero scale from reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            buf_entry <= qdsw_pkg::ENTRY_RST;
            dac_entry <= qdsw_pkg::ENTRY_RST;
            out_mode  <= qdsw_pkg::OUT_ACTIVE;
        end else begin
            buf_entry <= next_buf;
            dac_entry <= next_dac;
            out_mode  <= next_mode;
        end
    end
endmodule

// ==== rtl/qdsw_serial_write_port.sv ====
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module qdsw_serial_write_port (
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    input  wire logic [3:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output logic      [31:0]             avs_readdata,
    output logic                         avs_waitrequest,
    input  wire logic                    ser_clk,
    input  wire logic                    frame_sel_n,
    input  wire logic                    ser_din,
    input  wire logic                    addr_strap_hi,
    input  wire logic                    addr_strap_lo,
    output logic      [3:0][15:0]        dac_code,
    output logic      [3:0][1:0]         dac_out_mode
);
    localparam int NCH = qdsw_pkg::NUM_CH;

    // ---------------- Link domain, falling edge of serial clock
    logic                                link_rst;
    logic [qdsw_pkg::WORD_BITS-1:0]      shift;
    logic [qdsw_pkg::WORD_BITS-1:0]      next_shift;
    logic [qdsw_pkg::CNT_W-1:0]          bit_cnt;
    logic [qdsw_pkg::CNT_W-1:0]          next_bit_cnt;
    logic [qdsw_pkg::WORD_BITS-1:0]      word_hold;
    logic [qdsw_pkg::WORD_BITS-1:0]      next_word_hold;
    logic                                word_tog;
    logic                                next_word_tog;

    // Select high holds the shifter cleared and ends any partial frame
    assign link_rst = frame_sel_n | reset;

    always_comb begin
        next_shift     = shift;
        next_bit_cnt   = bit_cnt;
        next_word_hold = word_hold;
        next_word_tog  = word_tog;
        if (bit_cnt < qdsw_pkg::WORD_CNT) begin
            next_shift   = {shift[qdsw_pkg::WORD_BITS-2:0], ser_din};
            next_bit_cnt = bit_cnt + 5'h01;
            if (bit_cnt == qdsw_pkg::WORD_CNT - 5'h01) begin
                next_word_hold = next_shift;
                next_word_tog  = ~word_tog;
            end
        end
    end

    always_ff @(negedge ser_clk or posedge link_rst) begin
        if (link_rst) begin
            shift   <= '0;
            bit_cnt <= '0;
        end else begin
            shift   <= next_shift;
            bit_cnt <= next_bit_cnt;
        end
    end

    // Completed word stays frozen until the next full frame
    always_ff @(negedge ser_clk or posedge reset) begin
        if (reset) begin
            word_hold <= '0;
            word_tog  <= 1'b0;
        end else begin
            word_hold <= next_word_hold;
            word_tog  <= next_word_tog;
        end
    end

    // ---------------- Crossing into the system domain
    logic                                tog_sync;
    logic                                tog_seen;
    logic                                next_tog_seen;
    logic [1:0]                          strap_sync;
    logic                                word_evt;

    qdsw_sync #(.W(1)) u_tog_sync (
        .clk   (sys_clk),
        .reset (reset),
        .d     (word_tog),
        .q     (tog_sync)
    );

    qdsw_sync #(.W(2)) u_strap_sync (
        .clk   (sys_clk),
        .reset (reset),
        .d     ({addr_strap_hi, addr_strap_lo}),
        .q     (strap_sync)
    );

    assign word_evt = tog_sync ^ tog_seen;

    always_comb begin
        next_tog_seen = tog_sync;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tog_seen <= 1'b0;
        end else begin
            tog_seen <= next_tog_seen;
        end
    end

    // ---------------- Command decode
    logic                                port_en;
    logic [1:0]                          load_sel;
    logic [1:0]                          ch_sel;
    logic                                addr_match;
    logic                                is_bcast;
    logic                                accept;
    logic                                ignore;
    logic [qdsw_pkg::ENTRY_BITS-1:0]     entry;
    logic [NCH-1:0][16:0]                buf_entry;
    logic [NCH-1:0][16:0]                dac_entry;

    assign load_sel   = word_hold[qdsw_pkg::POS_LOAD_HI:qdsw_pkg::POS_LOAD_LO];
    assign ch_sel     = word_hold[qdsw_pkg::POS_SEL_HI:qdsw_pkg::POS_SEL_LO];
    assign entry      = word_hold[qdsw_pkg::ENTRY_BITS-1:0];
    assign is_bcast   = (load_sel == qdsw_pkg::LOAD_BCAST);
    assign addr_match = (word_hold[qdsw_pkg::POS_ADDR_HI] == strap_sync[1])
                      && (word_hold[qdsw_pkg::POS_ADDR_LO] == strap_sync[0]);
    assign accept     = word_evt && port_en && (addr_match || is_bcast);
    assign ignore     = word_evt && !(port_en && (addr_match || is_bcast));

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            logic hit;
            logic wr_buf;
            logic to_word;
            logic to_buf;
            assign hit = (ch_sel == 2'(gi));

            always_comb begin
                wr_buf  = 1'b0;
                to_word = 1'b0;
                to_buf  = 1'b0;
                if (accept) begin
                    unique case (load_sel)
                        qdsw_pkg::LOAD_STORE: begin
                            wr_buf = hit;
                        end
                        qdsw_pkg::LOAD_UPDATE: begin
                            wr_buf  = hit;
                            to_word = hit;
                        end
                        qdsw_pkg::LOAD_SIMUL: begin
                            wr_buf  = hit;
                            to_word = hit;
                            to_buf  = !hit;
                        end
                        qdsw_pkg::LOAD_BCAST: begin
                            wr_buf  = word_hold[qdsw_pkg::POS_SEL_HI];
                            to_word = word_hold[qdsw_pkg::POS_SEL_HI];
                            to_buf  = !word_hold[qdsw_pkg::POS_SEL_HI];
                        end
                    endcase
                end
            end

            qdsw_channel u_channel (
                .clk           (sys_clk),
                .reset         (reset),
                .buf_wr        (wr_buf),
                .dac_from_word (to_word),
                .dac_from_buf  (to_buf),
                .entry         (entry),
                .buf_entry     (buf_entry[gi]),
                .dac_entry     (dac_entry[gi]),
                .out_mode      (dac_out_mode[gi])
            );

            assign dac_code[gi] = dac_entry[gi][qdsw_pkg::DATA_BITS-1:0];
        end
    endgenerate

    // ---------------- Status and counters
    logic [qdsw_pkg::WORD_BITS-1:0]      last_word;
    logic [qdsw_pkg::WORD_BITS-1:0]      next_last_word;
    logic [15:0]                         accept_cnt;
    logic [15:0]                         next_accept_cnt;
    logic [15:0]                         ignore_cnt;
    logic [15:0]                         next_ignore_cnt;

    always_comb begin
        next_last_word  = last_word;
        next_accept_cnt = accept_cnt;
        next_ignore_cnt = ignore_cnt;
        if (word_evt) begin
            next_last_word = word_hold;
        end
        if (accept) begin
            next_accept_cnt = accept_cnt + 16'h0001;
        end
        if (ignore) begin
            next_ignore_cnt = ignore_cnt + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            last_word  <= '0;
            accept_cnt <= qdsw_pkg::COUNT_RST;
            ignore_cnt <= qdsw_pkg::COUNT_RST;
        end else begin
            last_word  <= next_last_word;
            accept_cnt <= next_accept_cnt;
            ignore_cnt <= next_ignore_cnt;
        end
    end

    // ---------------- Avalon-MM slave, one wait state per access
    logic                                ack;
    logic                                next_ack;
    logic                                next_port_en;
    logic [31:0]                         next_readdata;
    logic                                req;
    logic                                ctrl_wr;
    logic                                rd_take;

    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack;
    // Write lands at the edge where waitrequest is low
    assign ctrl_wr         = avs_write && ack && (avs_address == qdsw_pkg::REG_CTRL)
                           && avs_byteenable[0];
    // Read data loads at the first edge and stands through the answer
    assign rd_take         = avs_read && !ack;

    always_comb begin
        next_ack = req & ~ack;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ack <= 1'b0;
        end else begin
            ack <= next_ack;
        end
    end

    always_comb begin
        next_port_en = port_en;
        if (ctrl_wr) begin
            next_port_en = avs_writedata[qdsw_pkg::CTRL_EN_BIT];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            port_en <= qdsw_pkg::CTRL_EN_RST;
        end else begin
            port_en <= next_port_en;
        end
    end

    always_comb begin
        next_readdata = avs_readdata;
        if (rd_take) begin
            unique case (avs_address)
                qdsw_pkg::REG_CTRL:   next_readdata = {31'h0000_0000, port_en};
                qdsw_pkg::REG_STATUS: next_readdata = {8'h00, last_word};
                qdsw_pkg::REG_COUNT:  next_readdata = {ignore_cnt, accept_cnt};
                qdsw_pkg::REG_DAC0,
                qdsw_pkg::REG_DAC0 + 4'h1,
                qdsw_pkg::REG_DAC0 + 4'h2,
                qdsw_pkg::REG_DAC0 + 4'h3: begin
                    next_readdata = {15'h0000, dac_entry[avs_address[1:0]]};
                end
                qdsw_pkg::REG_BUF0,
                qdsw_pkg::REG_BUF0 + 4'h1,
                qdsw_pkg::REG_BUF0 + 4'h2,
                qdsw_pkg::REG_BUF0 + 4'h3: begin
                    next_readdata = {15'h0000, buf_entry[avs_address[1:0]]};
                end
                default: next_readdata = qdsw_pkg::READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            avs_readdata <= qdsw_pkg::READ_ZERO;
        end else begin
            avs_readdata <= next_readdata;
        end
    end
endmodule

// ==== verif/qdsw_host_model.sv ====
`timescale 1ns/1ps
module qdsw_host_model (
    output logic ser_clk,
    output logic frame_sel_n,
    output logic ser_din
);
    localparam int HALF_NS = 32;  // 64 ns serial clock, inside both speed limits
    localparam int GAP_NS  = 200; // Idle time before the next select fall

    initial begin
        ser_clk     = 1'b1;
        frame_sel_n = 1'b1;
        ser_din     = 1'b0;
    end

    // Sends nbits of w MSB first, then extra clocks carrying flipped data
    task automatic send_frame(input logic [23:0] w, input int nbits, input int extra);
        int i;
        frame_sel_n = 1'b0;
        for (i = 0; i < nbits + extra; i++) begin
            ser_din = (i < 24) ? w[23 - i] : ~ser_din;
            #HALF_NS ser_clk = 1'b0;
            #HALF_NS ser_clk = 1'b1;
        end
        #HALF_NS frame_sel_n = 1'b1;
        ser_din = ~ser_din;
        #GAP_NS;
    endtask
endmodule

// ==== verif/qdsw_assertions.sv ====
`timescale 1ns/1ps
module qdsw_checker (
    input wire logic             sys_clk,
    input wire logic             reset,
    input wire logic [3:0]       avs_address,
    input wire logic             avs_read,
    input wire logic             avs_write,
    input wire logic [31:0]      avs_writedata,
    input wire logic [3:0]       avs_byteenable,
    input wire logic [31:0]      avs_readdata,
    input wire logic             avs_waitrequest,
    input wire logic             ser_clk,
    input wire logic             frame_sel_n,
    input wire logic             ser_din,
    input wire logic             addr_strap_hi,
    input wire logic             addr_strap_lo,
    input wire logic [3:0][15:0] dac_code,
    input wire logic [3:0][1:0]  dac_out_mode
);
    logic [4:0] edge_cnt;
    logic       done_tgl;
    logic [2:0] done_sync;
    logic [3:0] since_done;
    logic       done_p;

    assign done_p = done_sync[2] ^ done_sync[1];

    // Counts falling serial edges of the open frame
    always_ff @(negedge ser_clk or posedge frame_sel_n or posedge reset) begin
        if (reset) begin
            edge_cnt <= 5'h00;
        end else if (frame_sel_n) begin
            edge_cnt <= 5'h00;
        end else if (edge_cnt != qdsw_pkg::WORD_CNT) begin
            edge_cnt <= edge_cnt + 5'h01;
        end
    end

    always_ff @(negedge ser_clk or posedge reset) begin
        if (reset) begin
            done_tgl <= 1'b0;
        end else if (!frame_sel_n && edge_cnt == 5'h17) begin
            done_tgl <= ~done_tgl;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            done_sync  <= 3'h0;
            since_done <= 4'hf;
        end else begin
            done_sync  <= {done_sync[1:0], done_tgl};
            since_done <= done_p ? 4'h0 : (since_done == 4'hf ? 4'hf : since_done + 4'h1);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    wait_first_a: assert property (($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest)
        else $error("waitrequest low in first request cycle");
    one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait state");
    ack_drop_a: assert property ((avs_read || avs_write) && !avs_waitrequest
        |=> !(avs_read || avs_write) || avs_waitrequest)
        else $error("next request answered without wait state");
    idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high with no request");
    rdata_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("readdata changed without a read");
    zero_reset_a: assert property ($fell(reset) |-> dac_code == '0 && dac_out_mode == '0)
        else $error("outputs not zero after reset");
    code_cause_a: assert property (!$stable(dac_code) |-> since_done <= 4'h6)
        else $error("dac code changed without a completed word");
    mode_cause_a: assert property (!$stable(dac_out_mode) |-> since_done <= 4'h6)
        else $error("output mode changed without a completed word");

    rd_c: cover property (avs_read && !avs_waitrequest);
    wr_c: cover property (avs_write && !avs_waitrequest);
    done_c: cover property (done_p);
    pd_c: cover property (dac_out_mode != '0);
endmodule

bind qdsw_serial_write_port qdsw_checker chk_u (
    .sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ser_clk(ser_clk),
    .frame_sel_n(frame_sel_n), .ser_din(ser_din), .addr_strap_hi(addr_strap_hi),
    .addr_strap_lo(addr_strap_lo), .dac_code(dac_code), .dac_out_mode(dac_out_mode)
);

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic             sys_clk, reset, avs_read, avs_write, avs_waitrequest;
    logic [3:0]       avs_address, avs_byteenable;
    logic [31:0]      avs_writedata, avs_readdata, lfsr, rd;
    logic             ser_clk, frame_sel_n, ser_din, addr_strap_hi, addr_strap_lo, en_m;
    logic [3:0][15:0] dac_code;
    logic [3:0][1:0]  dac_out_mode;
    logic [16:0]      buf_m [4];
    logic [16:0]      dac_m [4];
    logic [15:0]      acc_m, ign_m;
    logic [23:0]      w;
    int               err_count, n_tests, cyc, i;

    qdsw_serial_write_port dut_u (
        .sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ser_clk(ser_clk),
        .frame_sel_n(frame_sel_n), .ser_din(ser_din), .addr_strap_hi(addr_strap_hi),
        .addr_strap_lo(addr_strap_lo), .dac_code(dac_code), .dac_out_mode(dac_out_mode));
    qdsw_host_model host_u (.ser_clk(ser_clk), .frame_sel_n(frame_sel_n), .ser_din(ser_din));

    always #12.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("compares %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic void rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    endfunction

    // One Avalon access, held until waitrequest is seen low
    task automatic avs_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                            output logic [31:0] d);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_read      <= ~wr;
        avs_write     <= wr;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    function automatic logic [1:0] mode_of(input logic [16:0] e);
        if (!e[16]) return qdsw_pkg::OUT_ACTIVE;
        case (e[15:14])
            2'h1: return qdsw_pkg::OUT_1K;
            2'h2: return qdsw_pkg::OUT_100K;
            default: return qdsw_pkg::OUT_HIZ;
        endcase
    endfunction

    // Reference model of one completed word
    function automatic void apply(input logic [23:0] x);
        int k;
        if (!en_m || (x[21:20] != 2'h3 && x[23:22] != {addr_strap_hi, addr_strap_lo})) begin
            ign_m++;
            return;
        end
        acc_m++;
        if (x[21:20] != 2'h3) buf_m[x[18:17]] = x[16:0];
        else if (x[18]) for (k = 0; k < 4; k++) buf_m[k] = x[16:0];
        if (x[21:20] == 2'h1) dac_m[x[18:17]] = x[16:0];
        else if (x[21]) for (k = 0; k < 4; k++) dac_m[k] = buf_m[k];
    endfunction

    task automatic check_all();
        int k;
        for (k = 0; k < qdsw_pkg::NUM_CH; k++) begin
            chk(32'(dac_code[k]), 32'(dac_m[k][15:0]));
            chk(32'(dac_out_mode[k]), 32'(mode_of(dac_m[k])));
        end
    endtask

    task automatic frame(input logic [23:0] x, input int extra);
        host_u.send_frame(x, 24, extra);
        repeat (2) @(posedge sys_clk);
        apply(x);
        check_all();
        avs_xfer(1'b0, qdsw_pkg::REG_STATUS, 32'h0, rd);
        chk(rd, {8'h00, x});
        avs_xfer(1'b0, qdsw_pkg::REG_BUF0 + {2'h0, x[18:17]}, 32'h0, rd);
        chk(rd, 32'(buf_m[x[18:17]]));
        avs_xfer(1'b0, qdsw_pkg::REG_DAC0 + {2'h0, x[18:17]}, 32'h0, rd);
        chk(rd, 32'(dac_m[x[18:17]]));
    endtask

    initial begin
        sys_clk = 1'b0; reset = 1'b1; avs_read = 1'b0; avs_write = 1'b0;
        avs_address = 4'h0; avs_writedata = 32'h0; avs_byteenable = 4'hf;
        lfsr = 32'hb294_b0f3; addr_strap_hi = lfsr[5]; addr_strap_lo = lfsr[9];
        en_m = 1'b1; acc_m = 16'h0; ign_m = 16'h0;
        for (i = 0; i < 4; i++) begin
            buf_m[i] = 17'h0_0000;
            dac_m[i] = 17'h0_0000;
        end
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check_all();
        avs_xfer(1'b0, qdsw_pkg::REG_CTRL, 32'h0, rd);
        chk(rd, 32'h0000_0001);
        avs_xfer(1'b1, qdsw_pkg::REG_DAC0, 32'hffff_ffff, rd);
        avs_xfer(1'b0, qdsw_pkg::REG_DAC0, 32'h0, rd);
        chk(rd, 32'h0000_0000);
        avs_xfer(1'b0, 4'h3, 32'h0, rd);
        chk(rd, 32'h0000_0000);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            w = {addr_strap_hi, addr_strap_lo, 2'(i), 1'b0, 2'(i), 1'b1, 2'(i), 14'h0abc};
            frame(w, 0);
        end
        frame({~addr_strap_hi, addr_strap_lo, 2'h3, 1'b0, 2'h0, 1'b0, 16'h1234}, 0);
        $display("test codes done");
        for (i = 0; i < 40; i++) begin
            rnd();
            w = lfsr[23:0];
            if (lfsr[31:30] != 2'h0) w[23:22] = {addr_strap_hi, addr_strap_lo};
            frame(w, int'(lfsr[27:26]));
            if (i == 20) begin
                addr_strap_hi <= lfsr[3];
                addr_strap_lo <= lfsr[12];
                repeat (4) @(posedge sys_clk);
            end
        end
        $display("test random done");
        rnd();
        host_u.send_frame({addr_strap_hi, addr_strap_lo, 2'h1, lfsr[19:0]}, 23, 0);
        repeat (2) @(posedge sys_clk);
        check_all();
        avs_xfer(1'b0, qdsw_pkg::REG_STATUS, 32'h0, rd);
        chk(rd, {8'h00, w});
        avs_byteenable <= 4'he;
        avs_xfer(1'b1, qdsw_pkg::REG_CTRL, 32'h0, rd);
        avs_byteenable <= 4'hf;
        avs_xfer(1'b0, qdsw_pkg::REG_CTRL, 32'h0, rd);
        chk(rd, 32'h0000_0001);
        avs_xfer(1'b1, qdsw_pkg::REG_CTRL, 32'h0, rd);
        en_m = 1'b0;
        frame({addr_strap_hi, addr_strap_lo, 2'h1, lfsr[29:10]}, 0);
        avs_xfer(1'b1, qdsw_pkg::REG_CTRL, 32'h1, rd);
        en_m = 1'b1;
        avs_xfer(1'b0, qdsw_pkg::REG_COUNT, 32'h0, rd);
        chk(rd, {ign_m, acc_m});
        $display("test abort done");
        summarize();
    end
endmodule
